// >>> hdl/pmr_defines.vh
`ifndef PMR_DEFINES_VH
`define PMR_DEFINES_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PMR_DISP_GEN_CFG     8'h95
`define PMR_DISP_CLK_SEL     8'h96
`define PMR_DISP_SEG_EN_A    8'h97
`define PMR_DISP_CFG_X       8'h9c
`define PMR_RTC_CFG          8'ha1
`define PMR_RTC_CENTI        8'ha2
`define PMR_RTC_S            8'ha3
`define PMR_RTC_M            8'ha4
`define PMR_RTC_H            8'ha5
`define PMR_RTC_ALARM_INT    8'ha6
`define PMR_DISP_MEM_PTR     8'hac
`define PMR_DISP_MEM_DAT     8'hae
`define PMR_DISP_CFG_Y       8'hb1
`define PMR_PORT0_PULLUP     8'hb2
`define PMR_PORT1_PULLUP     8'hb3
`define PMR_PORT2_PULLUP     8'hb4
`define PMR_DISP_SEG_EN_B    8'hed
`define PMR_PERIPHERAL_CONFIG_CFG       8'hf4
`define PMR_BAT_SW_CFG       8'hf5
`define PMR_RTC_NOM_COMP     8'hf6
`define PMR_RTC_TEMP_COMP    8'hf7
`define PMR_PAD_ONE          8'hfb
`define PMR_PAD_TWO          8'hfc
`define PMR_PAD_THREE        8'hfd
`define PMR_PAD_FOUR         8'hfe
`define PMR_INT_PIN_CFG      8'hff
`define PMR_POWER_CTRL       8'hc5
`define PMR_METER_MODE_ONE   8'h0b
`define PMR_MODE_STATUS      8'hc6
`define PMR_PERIPHERAL_CONFIG_SLEEP_EN  8'hc7
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PMR_SLEEP_BIT        4
`define PMR_METER_PD_BIT     4
`define PMR_SUPPLY_SRC_BIT   6
`define PMR_CLKDIV_RST       3'h3
`define PMR_PWRCTL_RST       8'h03
`define PMR_REG_RST          8'h00
`define PMR_PSLEEP_RST       8'h03
// ----------------------------------------
// Timing
// ----------------------------------------
`define PMR_CLK_HZ           125000000
`define PMR_RESTORE_MS       130
`define PMR_RESTORE_CYC      (`PMR_CLK_HZ / 1000 * `PMR_RESTORE_MS)
`endif

// >>> hdl/pmr_sync.v
`timescale 1ns/100ps
module pmr_sync (
	input  wire clk,
	input  wire nrst,
	input  wire d,
	output wire q
);
	reg meta_r;
	reg q_r;
	always @(posedge clk) begin
		if (!nrst) begin
			meta_r <= 1'b0;
			q_r    <= 1'b0;
		end else begin
			meta_r <= d;
			q_r    <= meta_r;
		end
	end
	assign q = q_r;
endmodule

// >>> hdl/pmr_power_mode_retention_ctrl.v
// Function
// [RULE1] Normal mode: switched output on main supply.
// [RULE2] Normal mode: both internal rails enabled.
// [RULE3] Reset sets core clock to 1.024 MHz.
// [RULE4] Battery run: switched output on battery.
// [RULE5] Battery run: core and digital stay enabled.
// [RULE6] Battery run: metering analog rail disabled.
// [RULE7] Restore needs supply good, power-down clear.
// [RULE8] Sleep keeps switched output on battery.
// [RULE9] Sleep shuts down core and both rails.
// [RULE10] Sleep entry marks data RAM invalid.
// [RULE11] Sleep exit restarts from reset vector.
// [RULE12] Always-on peripherals powered during sleep.
// [RULE13] Each always-on peripheral individually sleep-enabled.
// [RULE14] Firmware configures sleep peripherals before sleeping.
// [RULE15] Sleep holds until a wake event.
// [RULE16] Four scratch-pad registers survive sleep.
// [RULE17] Listed configuration registers survive sleep.
// [RULE18] Firmware restores other registers after sleep.
// [RULE19] Enabled switchover event forces battery run.
// [RULE20] Sleep bit in power control enters sleep.
// [RULE21] Restore from battery run keeps code running.
// [RULE22] Wait 130 ms before returning to main.
// [RULE23] Mode is a three-state encoded value.
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`include "pmr_defines.vh"
module pmr_power_mode_retention_ctrl #(
	parameter [31:0] RESTORE_CYC = `PMR_RESTORE_CYC
) (
	input  wire       clk,
	input  wire       nrst,
	input  wire [7:0] addr,
	input  wire [7:0] wdata,
	input  wire       wr,
	input  wire       rd,
	output wire [7:0] rdata,
	input  wire       main_supply_good,
	input  wire       switchover_event,
	input  wire       wake_event,
	output wire       supply_on_main,
	output wire       analog_rail_en,
	output wire       digital_rail_en,
	output wire       metering_analog_en,
	output wire       core_run,
	output wire [2:0] core_clk_div,
	output wire       ram_invalid,
	output wire       core_restart,
	output wire       aon_supply_en,
	output wire [7:0] aon_peripheral_config_en,
	output wire [1:0] mode
);
	// ----------------------------------------
	// Mode codes
	// ----------------------------------------
	localparam [1:0] NORMAL_SUPPLY_MODE = 2'h0;
	localparam [1:0] BATTERY_RUN_MODE   = 2'h1;
	localparam [1:0] BATTERY_SLEEP_MODE = 2'h2;

	wire       good_s;
	wire       swo_s;
	wire       wake_s;
	reg  [1:0] mode_r;
	reg  [1:0] mode_nxt;
	reg  [31:0] wait_r;
	reg  [2:0] clkdiv_r;
	reg  [7:0] meter_r;
	reg  [7:0] psleep_r;
	reg        ram_inv_r;
	reg        restart_r;
	reg  [7:0] rdata_r;
	reg  [7:0] ret_r [0:25];
	reg  [4:0] idx;
	reg        hit;
	reg  [7:0] rd_nxt;
	integer    i;

	pmr_sync u_good (.clk(clk), .nrst(nrst), .d(main_supply_good), .q(good_s));
	pmr_sync u_swo  (.clk(clk), .nrst(nrst), .d(switchover_event), .q(swo_s));
	pmr_sync u_wake (.clk(clk), .nrst(nrst), .d(wake_event),       .q(wake_s));

	// ----------------------------------------
	// Retained register decode
	// ----------------------------------------
	always @* begin
		hit = 1'b1;
		case (addr)
			`PMR_DISP_GEN_CFG:  idx = 5'd0;
			`PMR_DISP_CLK_SEL:  idx = 5'd1;
			`PMR_DISP_SEG_EN_A: idx = 5'd2;
			`PMR_DISP_CFG_X:    idx = 5'd3;
			`PMR_RTC_CFG:       idx = 5'd4;
			`PMR_RTC_CENTI:     idx = 5'd5;
			`PMR_RTC_S:         idx = 5'd6;
			`PMR_RTC_M:         idx = 5'd7;
			`PMR_RTC_H:         idx = 5'd8;
			`PMR_RTC_ALARM_INT: idx = 5'd9;
			`PMR_DISP_MEM_PTR:  idx = 5'd10;
			`PMR_DISP_MEM_DAT:  idx = 5'd11;
			`PMR_DISP_CFG_Y:    idx = 5'd12;
			`PMR_PORT0_PULLUP:  idx = 5'd13;
			`PMR_PORT1_PULLUP:  idx = 5'd14;
			`PMR_PORT2_PULLUP:  idx = 5'd15;
			`PMR_DISP_SEG_EN_B: idx = 5'd16;
			`PMR_PERIPHERAL_CONFIG_CFG:    idx = 5'd17;
			`PMR_BAT_SW_CFG:    idx = 5'd18;
			`PMR_RTC_NOM_COMP:  idx = 5'd19;
			`PMR_RTC_TEMP_COMP: idx = 5'd20;
			`PMR_PAD_ONE:       idx = 5'd21;
			`PMR_PAD_TWO:       idx = 5'd22;
			`PMR_PAD_THREE:     idx = 5'd23;
			`PMR_PAD_FOUR:      idx = 5'd24;
			`PMR_INT_PIN_CFG:   idx = 5'd25;
			default: begin
				idx = 5'd0;
				hit = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Mode machine
	// ----------------------------------------
	wire restore_ok = good_s & ~meter_r[`PMR_METER_PD_BIT]; // [RULE7]
	wire wait_done  = (wait_r >= RESTORE_CYC - 32'd1);
	wire sleep_req  = wr & (addr == `PMR_POWER_CTRL) & wdata[`PMR_SLEEP_BIT];

	always @* begin
		mode_nxt = mode_r;
		case (mode_r)
			NORMAL_SUPPLY_MODE: begin
				if (swo_s)
					mode_nxt = BATTERY_RUN_MODE; // [RULE19]
			end
			BATTERY_RUN_MODE: begin
				if (sleep_req)
					mode_nxt = BATTERY_SLEEP_MODE; // [RULE20]
				else if (restore_ok & ~swo_s & wait_done)
					mode_nxt = NORMAL_SUPPLY_MODE; // [RULE21] [RULE22]
			end
			BATTERY_SLEEP_MODE: begin
				// The core is off here, so only a wake or a restore can leave.
				if (restore_ok & ~swo_s & wait_done)
					mode_nxt = NORMAL_SUPPLY_MODE; // [RULE22]
				else if (wake_s)
					mode_nxt = BATTERY_RUN_MODE; // [RULE15]
			end
			default: mode_nxt = NORMAL_SUPPLY_MODE;
		endcase
	end

	always @(posedge clk) begin
		if (!nrst) begin
			mode_r    <= NORMAL_SUPPLY_MODE;
			wait_r    <= 32'h0;
			ram_inv_r <= 1'b0;
			restart_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt; // [RULE23]
			if (mode_r != NORMAL_SUPPLY_MODE && restore_ok && !swo_s && !wait_done)
				wait_r <= wait_r + 32'd1;
			else if (!(restore_ok && !swo_s))
				wait_r <= 32'h0;
			else if (mode_nxt == NORMAL_SUPPLY_MODE)
				wait_r <= 32'h0;
			if (mode_nxt == BATTERY_SLEEP_MODE && mode_r != BATTERY_SLEEP_MODE)
				ram_inv_r <= 1'b1; // [RULE10]
			else if (restart_r)
				ram_inv_r <= 1'b0;
			// A one-cycle restart pulse on every sleep exit, never a resume.
			restart_r <= (mode_r == BATTERY_SLEEP_MODE) &&
				(mode_nxt != BATTERY_SLEEP_MODE); // [RULE11]
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	// Retained registers reset only on nrst; a mode change never touches them.
	always @(posedge clk) begin
		if (!nrst) begin
			for (i = 0; i < 26; i = i + 1)
				ret_r[i] <= `PMR_REG_RST; // [RULE16] [RULE17]
			clkdiv_r <= `PMR_CLKDIV_RST; // [RULE3]
			meter_r  <= `PMR_REG_RST;
			psleep_r <= `PMR_PSLEEP_RST;
		end else begin
			if (wr && hit && mode_r != BATTERY_SLEEP_MODE)
				ret_r[idx] <= wdata;
			if (restart_r)
				clkdiv_r <= `PMR_CLKDIV_RST; // [RULE3]
			else if (wr && addr == `PMR_POWER_CTRL)
				clkdiv_r <= wdata[2:0];
			// The sleep request bit is a strobe and is never stored.
			if (wr && addr == `PMR_METER_MODE_ONE)
				meter_r <= wdata;
			if (wr && addr == `PMR_PERIPHERAL_CONFIG_SLEEP_EN && mode_r != BATTERY_SLEEP_MODE)
				psleep_r <= wdata; // [RULE13] [RULE14]
		end
	end

	always @* begin
		rd_nxt = 8'h00;
		if (hit) begin
			rd_nxt = ret_r[idx];
			if (addr == `PMR_PERIPHERAL_CONFIG_CFG)
				rd_nxt[`PMR_SUPPLY_SRC_BIT] = supply_on_main;
		end else begin
			case (addr)
				`PMR_POWER_CTRL:      rd_nxt = {5'h0, clkdiv_r};
				`PMR_METER_MODE_ONE:  rd_nxt = meter_r;
				`PMR_PERIPHERAL_CONFIG_SLEEP_EN: rd_nxt = psleep_r;
				`PMR_MODE_STATUS:     rd_nxt = {5'h0, ram_inv_r, mode_r};
				default:              rd_nxt = 8'h00;
			endcase
		end
	end

	always @(posedge clk) begin
		if (!nrst)
			rdata_r <= 8'h00;
		else
			rdata_r <= rd ? rd_nxt : 8'h00;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	wire sleeping = (mode_r == BATTERY_SLEEP_MODE);
	assign supply_on_main     = (mode_r == NORMAL_SUPPLY_MODE); // [RULE1] [RULE4] [RULE8]
	assign analog_rail_en     = ~sleeping; // [RULE2] [RULE9]
	assign digital_rail_en    = ~sleeping; // [RULE5] [RULE9]
	assign metering_analog_en = supply_on_main; // [RULE6]
	assign core_run           = ~sleeping; // [RULE9]
	assign core_clk_div       = clkdiv_r;
	assign ram_invalid        = ram_inv_r;
	assign core_restart       = restart_r;
	assign aon_supply_en      = 1'b1; // [RULE12]
	assign aon_peripheral_config_en      = sleeping ? psleep_r : 8'hff; // [RULE13]
	assign mode               = mode_r;
	assign rdata              = rdata_r;
	// Firmware restores unretained registers after sleep exit. [RULE18]
endmodule

// >>> verification/pmr_assertions.sv
`timescale 1ns/100ps
module pmr_checker (
	input logic       clk,
	input logic       nrst,
	input logic [7:0] addr,
	input logic [7:0] wdata,
	input logic       wr,
	input logic       switchover_event,
	input logic       wake_event,
	input logic       supply_on_main,
	input logic       analog_rail_en,
	input logic       digital_rail_en,
	input logic       metering_analog_en,
	input logic       core_run,
	input logic [2:0] core_clk_div,
	input logic       ram_invalid,
	input logic       core_restart,
	input logic       aon_supply_en,
	input logic [1:0] mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_supply_src: assert property (
		supply_on_main == (mode == 2'h0)) else $error("supply source wrong");
	a_rails_awake: assert property (
		{analog_rail_en, digital_rail_en, core_run} == {3{mode != 2'h2}})
		else $error("rail enables wrong");
	a_meter_normal: assert property (
		metering_analog_en == (mode == 2'h0)) else $error("metering enable wrong");
	a_clk_default: assert property ($rose(nrst) |-> core_clk_div == 3'h3)
		else $error("core clock default wrong");
	a_ram_flag: assert property (
		mode == 2'h2 && $past(mode) != 2'h2 |-> ##[0:1] ram_invalid)
		else $error("ram not marked invalid");
	a_restart_vec: assert property (
		$past(mode) == 2'h2 && mode != 2'h2 |-> ##[0:1] core_restart)
		else $error("no restart after sleep");
	a_restart_one: assert property (core_restart |=> !core_restart)
		else $error("restart pulse too long");
	a_aon_power: assert property (aon_supply_en)
		else $error("always-on supply off");
	a_sleep_hold: assert property (
		mode == 2'h2 ##1 mode == 2'h1 |-> $past(wake_event, 2) || $past(wake_event, 3))
		else $error("sleep left without wake");
	a_switch_cause: assert property (
		$past(mode) == 2'h0 && mode == 2'h1 |-> $past(switchover_event, 2))
		else $error("battery run without switchover");
	a_sleep_entry: assert property (
		mode == 2'h1 && wr && addr == 8'hc5 && wdata[4] |=> mode == 2'h2)
		else $error("sleep request not taken");
	a_mode_code: assert property (mode != 2'h3)
		else $error("illegal mode code");
	cover property (mode == 2'h2);
	cover property (core_restart);
	cover property (mode == 2'h1 ##1 mode == 2'h0);
endmodule
bind pmr_power_mode_retention_ctrl pmr_checker pmr_checker_inst (.*);

// >>> verification/power_mode_retention_ctrl_tb_top.sv
`timescale 1ns/100ps
`define CHK(n,e,a) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
	$display("Error %s exp %h got %h", n, e, a); end end
module power_mode_retention_ctrl_tb_top;
	logic        clk = 0;
	logic        nrst = 0;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 0;
	logic        rd = 0;
	logic        main_supply_good = 1;
	logic        switchover_event = 0;
	logic        wake_event = 0;
	logic        rd_q = 0;
	logic [7:0]  rdata, aon_peripheral_config_en, ev;
	logic [7:0]  n_rs = 8'h00;
	logic [2:0]  core_clk_div;
	logic [1:0]  mode;
	logic        supply_on_main, analog_rail_en, digital_rail_en, metering_analog_en;
	logic        core_run, ram_invalid, core_restart, aon_supply_en;
	logic [31:0] seed = 32'hcf456922;
	logic [7:0]  q[$];
	logic [7:0]  m[256];
	logic [7:0]  offs[13] = '{8'h95, 8'h9c, 8'ha1, 8'ha5, 8'hae, 8'hb2, 8'hb4,
		8'hed, 8'hf5, 8'hf7, 8'hfb, 8'hfe, 8'hff};
	int          n_mismatch = 0;
	int          checks_done = 0;

	// A short restore wait keeps the run brief; the count logic is the same.
	pmr_power_mode_retention_ctrl #(.RESTORE_CYC(20)) pmr_power_mode_retention_ctrl_inst (.*);

	always #4 clk = ~clk;

	always @(posedge clk) begin
		rd_q <= rd;
		n_rs <= n_rs + {7'h00, core_restart};
		if (rd_q) begin
			ev = q.pop_front();
			`CHK("rdata", ev, rdata)
		end
	end

	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	task automatic wrt(input logic [7:0] a, d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask

	task automatic rdc(input logic [7:0] a, e);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		q.push_back(e);
		@(posedge clk);
		rd <= 0;
	endtask

	task automatic st(input logic [1:0] v, input logic s, r, mt);
		for (int k = 0; k < 200 && mode !== v; k++) @(negedge clk);
		`CHK("mode", v, mode)
		`CHK("supply", s, supply_on_main)
		`CHK("rails", {r, r, r}, {analog_rail_en, digital_rail_en, core_run})
		`CHK("meter", mt, metering_analog_en)
	endtask

	task final_report;
		if (n_mismatch == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		#300000;
		n_mismatch++;
		final_report;
	end

	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1;
		@(negedge clk);
		`CHK("div", 3'h3, core_clk_div)
		`CHK("pen", 8'hff, aon_peripheral_config_en)
		st(2'h0, 1, 1, 1);
		rdc(8'hc7, 8'h03);
		rdc(8'hf4, 8'h40);
		rdc(8'h10, 8'h00);
		foreach (offs[i]) begin
			m[offs[i]] = xs();
			wrt(offs[i], m[offs[i]]);
		end
		wrt(8'hc7, 8'h05);
		wrt(8'hc5, 8'h10);
		repeat (3) @(negedge clk);
		st(2'h0, 1, 1, 1);
		wrt(8'h0b, 8'h10);
		main_supply_good <= 0;
		switchover_event <= 1;
		st(2'h1, 0, 1, 0);
		rdc(8'hf4, 8'h00);
		wrt(8'hc5, 8'h10);
		st(2'h2, 0, 0, 0);
		`CHK("ram", 1'b1, ram_invalid)
		`CHK("pen", 8'h05, aon_peripheral_config_en)
		wrt(8'hfb, ~m[8'hfb]);
		repeat (30) @(negedge clk);
		`CHK("mode", 2'h2, mode)
		@(posedge clk);
		wake_event <= 1;
		@(posedge clk);
		wake_event <= 0;
		st(2'h1, 0, 1, 0);
		repeat (3) @(negedge clk);
		`CHK("restarts", 8'h01, n_rs)
		`CHK("div", 3'h3, core_clk_div)
		foreach (offs[i]) rdc(offs[i], m[offs[i]]);
		rdc(8'hc6, 8'h01);
		switchover_event <= 0;
		main_supply_good <= 1;
		repeat (40) @(negedge clk);
		`CHK("mode", 2'h1, mode)
		wrt(8'h0b, 8'h00);
		repeat (10) @(negedge clk);
		`CHK("mode", 2'h1, mode)
		st(2'h0, 1, 1, 1);
		`CHK("restarts", 8'h01, n_rs)
		@(posedge clk);
		main_supply_good <= 0;
		switchover_event <= 1;
		st(2'h1, 0, 1, 0);
		wrt(8'hc5, 8'h10);
		st(2'h2, 0, 0, 0);
		@(posedge clk);
		switchover_event <= 0;
		main_supply_good <= 1;
		st(2'h0, 1, 1, 1);
		repeat (3) @(negedge clk);
		`CHK("restarts", 8'h02, n_rs)
		final_report;
	end
endmodule
